/* File: src/byte_and_bit_execute_ops.sv */
// Overview of operation
// - add accumulator, carry and file register
// - add with carry updates four flags
// - destination bit picks accumulator or file
// - and literal into accumulator, zero only
// - and accumulator with file, zero only
// - clear selected file bit, flags kept
// - set selected file bit, flags kept
// - test bit, skip next when zero
// - skipped instruction becomes a no-operation
// - file address 0..255, bit 0..7
module byte_and_bit_execute_ops
	import exec_ops_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        srst,
	input  wire logic [15:0] instr_word,
	output logic             instr_take,
	output logic [1:0]       phase,
	output logic [7:0]       file_addr,
	output logic             file_rd,
	input  wire logic [7:0]  file_rdata,
	output logic             file_wr,
	output logic [7:0]       file_wdata,
	output logic [7:0]       working_accumulator,
	output logic             carry_flag,
	output logic             nibble_carry_flag,
	output logic             signed_overflow_flag,
	output logic             zero_flag,
	output logic             skip_active,
	output logic             unknown_op
);

	phase_e     ph;
	phase_e     next_ph;
	op_e        op;
	op_e        next_op;
	logic [7:0] faddr;
	logic [7:0] next_faddr;
	logic [7:0] lit;
	logic [7:0] next_lit;
	logic [2:0] bsel;
	logic [2:0] next_bsel;
	logic       dest_file;
	logic       next_dest_file;
	logic       squash;
	logic       next_squash;
	logic       skip_req;
	logic       next_skip_req;
	logic       bad_op;
	logic       next_bad_op;
	logic [7:0] operand;
	logic [7:0] next_operand;
	logic [7:0] result;
	logic [7:0] next_result;
	logic [7:0] acc;
	logic [7:0] next_acc;
	logic       cf;
	logic       next_cf;
	logic       dcf;
	logic       next_dcf;
	logic       ovf;
	logic       next_ovf;
	logic       zf;
	logic       next_zf;
	logic       wr_pulse;
	logic       next_wr_pulse;
	logic [8:0] sum;
	logic [4:0] low_sum;

	// one-hot mask of the selected bit, shared by clear, set and test
	function automatic logic [7:0] bit_mask(input logic [2:0] b);
		bit_mask = 8'h01 << b;
	endfunction

	// opcode decode from the two upper nibbles
	function automatic op_e decode_op(input logic [15:0] w);
		logic [3:0] hi;
		logic [3:0] sub;
		hi  = w[OPC_HI_POS +: OPC_HI_W];
		sub = w[OPC_SUB_POS +: OPC_SUB_W];
		decode_op = OP_NONE;
		if (hi == OPC_ADDC_HI && sub[3:1] == OPC_ADDC_SUB[3:1])
			decode_op = OP_ADDC;
		else if (hi == OPC_ANDLIT_HI && sub == OPC_ANDLIT_SB)
			decode_op = OP_ANDLIT;
		else if (hi == OPC_ANDF_HI && sub[3:1] == OPC_ANDF_SUB[3:1])
			decode_op = OP_ANDF;
		else if (hi == OPC_BITOP_HI)
			decode_op = sub[3] ? OP_BCLR : OP_BSET;
		else if (hi == OPC_BTEST_HI && sub[3])
			decode_op = OP_BTEST;
	endfunction

	// adder kept outside the process so the carry chain is visible
	// accumulator, operand, carry summed
	assign sum     = {1'b0, acc} + {1'b0, operand} + {8'h00, cf};
	assign low_sum = {1'b0, acc[3:0]} + {1'b0, operand[3:0]} + {4'h0, cf};

	// phase sequencer; one instruction cycle is four clocks
	// decode, read, execute, write
	always_comb begin
		case (ph)
			PH_DECODE: next_ph = PH_READ;
			PH_READ:   next_ph = PH_EXEC;
			PH_EXEC:   next_ph = PH_WRITE;
			PH_WRITE:  next_ph = PH_DECODE;
			default:   next_ph = PH_DECODE;
		endcase
	end

	// phase register
	always_ff @(posedge clk) begin
		if (srst) begin
			ph <= PH_DECODE;
		end else begin
			ph <= next_ph;
		end
	end

	// instruction capture; fields load only at the end of decode
	always_comb begin
		next_op        = op;
		next_faddr     = faddr;
		next_lit       = lit;
		next_bsel      = bsel;
		next_dest_file = dest_file;
		next_bad_op    = bad_op;
		if (ph == PH_DECODE) begin
			if (squash) begin
				next_op     = OP_NONE;
				next_bad_op = 1'b0;
			end else begin
				next_op     = decode_op(instr_word);
				next_bad_op = (decode_op(instr_word) == OP_NONE);
			end
			next_faddr     = instr_word[FADDR_W-1:0];
			next_lit       = instr_word[FADDR_W-1:0];
			next_bsel      = instr_word[BIT_SEL_POS +: BIT_SEL_W];
			next_dest_file = instr_word[DEST_POS];
		end
	end

	// captured fields; address stays put until the next take
	always_ff @(posedge clk) begin
		if (srst) begin
			op        <= OP_NONE;
			faddr     <= 8'h00;
			lit       <= 8'h00;
			bsel      <= 3'h0;
			dest_file <= 1'b0;
			bad_op    <= 1'b0;
		end else begin
			op        <= next_op;
			faddr     <= next_faddr;
			lit       <= next_lit;
			bsel      <= next_bsel;
			dest_file <= next_dest_file;
			bad_op    <= next_bad_op;
		end
	end

	// skip bookkeeping; the squash flag is raised at the end of the test's
	// write phase so it covers every phase of the discarded slot
	always_comb begin
		next_skip_req = skip_req;
		next_squash   = squash;
		case (ph)
			PH_EXEC: begin
				next_skip_req = (op == OP_BTEST) && ((operand & bit_mask(bsel)) == 8'h00);
			end
			PH_WRITE: begin
				next_squash   = skip_req;
				next_skip_req = 1'b0;
			end
			default: next_skip_req = skip_req;
		endcase
	end

	// skip registers
	always_ff @(posedge clk) begin
		if (srst) begin
			squash   <= 1'b0;
			skip_req <= 1'b0;
		end else begin
			squash   <= next_squash;
			skip_req <= next_skip_req;
		end
	end

	// operand fetch and result; the literal bypasses the file bus
	always_comb begin
		next_operand = operand;
		next_result  = result;
		case (ph)
			PH_READ: next_operand = (op == OP_ANDLIT) ? lit : file_rdata;
			PH_EXEC: begin
				case (op)
					OP_ADDC:            next_result = sum[7:0];
					OP_ANDLIT, OP_ANDF: next_result = acc & operand;
					OP_BCLR:            next_result = operand & ~bit_mask(bsel);
					OP_BSET:            next_result = operand | bit_mask(bsel);
					OP_BTEST:           next_result = operand;
					default:            next_result = result;
				endcase
			end
			default: next_result = result;
		endcase
	end

	// operand and result registers
	always_ff @(posedge clk) begin
		if (srst) begin
			operand <= 8'h00;
			result  <= 8'h00;
		end else begin
			operand <= next_operand;
			result  <= next_result;
		end
	end

	// flags move at the end of execute, the accumulator at the end of write
	always_comb begin
		next_acc = acc;
		next_cf  = cf;
		next_dcf = dcf;
		next_ovf = ovf;
		next_zf  = zf;
		if (ph == PH_EXEC) begin
			case (op)
				OP_ADDC: begin
					next_cf  = sum[8];
					next_dcf = low_sum[4];
					next_ovf = (acc[7] == operand[7]) && (sum[7] != acc[7]);
					next_zf  = (sum[7:0] == 8'h00);
				end
				OP_ANDLIT, OP_ANDF: next_zf = ((acc & operand) == 8'h00);
				default:            next_zf = zf;
			endcase
		end else if (ph == PH_WRITE) begin
			if ((op == OP_ANDLIT) || (((op == OP_ADDC) || (op == OP_ANDF)) && !dest_file))
				next_acc = result;
		end
	end

	// accumulator and status registers
	always_ff @(posedge clk) begin
		if (srst) begin
			acc <= ACC_RESET;
			cf  <= FLAG_RESET;
			dcf <= FLAG_RESET;
			ovf <= FLAG_RESET;
			zf  <= FLAG_RESET;
		end else begin
			acc <= next_acc;
			cf  <= next_cf;
			dcf <= next_dcf;
			ovf <= next_ovf;
			zf  <= next_zf;
		end
	end

	always_comb begin
		next_wr_pulse = 1'b0;
		if (ph == PH_WRITE) begin
			case (op)
				OP_ADDC, OP_ANDF: next_wr_pulse = dest_file;
				OP_BCLR, OP_BSET: next_wr_pulse = 1'b1;
				default:          next_wr_pulse = 1'b0;
			endcase
		end
	end

	// strobe is registered so it lines up with the registered result
	always_ff @(posedge clk) begin
		if (srst) begin
			wr_pulse <= 1'b0;
		end else begin
			wr_pulse <= next_wr_pulse;
		end
	end

	// outputs; the read strobe is combinational so data returns within read phase
	assign instr_take           = (ph == PH_DECODE);
	assign phase                = ph;
	assign file_addr            = faddr;
	assign file_rd              = (ph == PH_READ) && (op != OP_NONE) && (op != OP_ANDLIT);
	assign file_wr              = wr_pulse;
	assign file_wdata           = result;
	assign working_accumulator  = acc;
	assign carry_flag           = cf;
	assign nibble_carry_flag    = dcf;
	assign signed_overflow_flag = ovf;
	assign zero_flag            = zf;
	assign skip_active          = squash;
	assign unknown_op           = bad_op;

endmodule

/* File: src/exec_ops_pkg.sv */
package exec_ops_pkg;

	// instruction word fields
	localparam int OPC_HI_POS  = 12;
	localparam int OPC_HI_W    = 4;
	localparam int OPC_SUB_POS = 8;
	localparam int OPC_SUB_W   = 4;
	localparam int BIT_SEL_POS = 8;
	localparam int BIT_SEL_W   = 3;
	localparam int DEST_POS    = 8;
	localparam int FADDR_W     = 8;

	// opcode nibbles
	localparam logic [3:0] OPC_ADDC_HI   = 4'h1;
	localparam logic [3:0] OPC_ADDC_SUB  = 4'h0;
	localparam logic [3:0] OPC_ANDLIT_HI = 4'hb;
	localparam logic [3:0] OPC_ANDLIT_SB = 4'h5;
	localparam logic [3:0] OPC_ANDF_HI   = 4'h0;
	localparam logic [3:0] OPC_ANDF_SUB  = 4'ha;
	localparam logic [3:0] OPC_BITOP_HI  = 4'h8;
	localparam logic [3:0] OPC_BTEST_HI  = 4'h9;

	// reset values
	localparam logic [7:0] ACC_RESET   = 8'h00;
	localparam logic       FLAG_RESET  = 1'b0;
	localparam logic [1:0] PHASE_RESET = 2'h0;

	typedef enum logic [1:0] {
		PH_DECODE,
		PH_READ,
		PH_EXEC,
		PH_WRITE
	} phase_e;

	typedef enum logic [2:0] {
		OP_NONE,
		OP_ADDC,
		OP_ANDLIT,
		OP_ANDF,
		OP_BCLR,
		OP_BSET,
		OP_BTEST
	} op_e;

endpackage

/* File: verification/exec_checker.sv */
module exec_checker (
	input logic        clk,
	input logic        srst,
	input logic [15:0] instr_word,
	input logic        instr_take,
	input logic [1:0]  phase,
	input logic [7:0]  file_addr,
	input logic        file_rd,
	input logic [7:0]  file_rdata,
	input logic        file_wr,
	input logic [7:0]  file_wdata,
	input logic [7:0]  working_accumulator,
	input logic        carry_flag,
	input logic        nibble_carry_flag,
	input logic        signed_overflow_flag,
	input logic        zero_flag,
	input logic        skip_active,
	input logic        unknown_op
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge clk); endclocking
	default disable iff (srst);
	// a fresh word, not one a skip throws away
	wire go = phase == 2'h0 && !skip_active;
	property p_take; instr_take == (phase == 2'h0); endproperty
	a_take: assert property (p_take) else $error("take off decode");
	property p_step; 1 |=> phase == 2'($past(phase) + 2'h1); endproperty
	a_step: assert property (p_step) else $error("phase order");
	property p_rd; file_rd |-> phase == 2'h1 ##1 !file_rd; endproperty
	a_rd: assert property (p_rd) else $error("read off phase");
	property p_wr; file_wr |-> phase == 2'h0 ##1 !file_wr; endproperty
	a_wr: assert property (p_wr) else $error("write off phase");
	property p_bit; go && instr_word[15:13] == 3'h4
		|=> $stable({carry_flag, nibble_carry_flag, signed_overflow_flag, zero_flag})[*4]; endproperty
	a_bit: assert property (p_bit) else $error("bit op moved flags");
	property p_and; go && instr_word[15:8] == 8'hb5
		|-> ##4 working_accumulator == ($past(working_accumulator, 4) & 8'($past(instr_word, 4))); endproperty
	a_and: assert property (p_and) else $error("and literal");
	property p_add; go && instr_word[15:8] == 8'h10 |-> ##4 working_accumulator
		== 8'($past(working_accumulator, 4) + $past(file_rdata, 3) + $past(carry_flag, 4)); endproperty
	a_add: assert property (p_add) else $error("add carry");
	property p_andf; go && instr_word[15:8] == 8'h0b
		|-> ##4 file_wr && file_wdata == ($past(working_accumulator, 4) & $past(file_rdata, 3)); endproperty
	a_andf: assert property (p_andf) else $error("and to file");
	property p_skip; skip_active && phase == 2'h3 |=> !file_wr; endproperty
	a_skip: assert property (p_skip) else $error("skipped word wrote");
	property p_btest; go && instr_word[15:11] == 5'h13
		|-> ##4 skip_active == ((($past(file_rdata, 3) >> $past(instr_word[10:8], 4)) & 8'h01) == 8'h00); endproperty
	a_btest: assert property (p_btest) else $error("test skip wrong");
	c_skip: cover property (skip_active);
	c_wr: cover property (file_wr);
	c_unk: cover property (unknown_op);
endmodule

bind byte_and_bit_execute_ops exec_checker chk (.*);

/* File: verification/file_mem.sv */
module file_mem (
	input logic        clk,
	input logic        file_rd,
	input logic        file_wr,
	input logic [7:0]  file_addr,
	input logic [7:0]  file_wdata,
	output logic [7:0] file_rdata
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] mem[256];
	logic [7:0] last = 8'h00;
	initial foreach (mem[i]) mem[i] = 8'(i * 37 + 5);
	// idle bus shows inverted last data so a late sample cannot match
	assign file_rdata = file_rd ? mem[file_addr] : ~last;
	// write lands at the pulse; read value remembered for the idle pattern
	always @(posedge clk) begin
		if (file_rd) last <= mem[file_addr];
		if (file_wr) mem[file_addr] <= file_wdata;
	end
endmodule

/* File: verification/tb.sv */
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 1'b0;
	logic srst = 1'b1;
	logic [15:0] instr_word = 16'h0000;
	logic instr_take, file_rd, file_wr, carry_flag, nibble_carry_flag, signed_overflow_flag, zero_flag;
	logic skip_active, unknown_op;
	logic [1:0] phase;
	logic [7:0] file_addr, file_rdata, file_wdata, working_accumulator;
	int n_errors = 0;
	int num_checks = 0;
	int cyc = 0;
	// reference state kept apart from the design
	int mm[256];
	int acc = 0, c = 0, dc = 0, ov = 0, z = 0, skip = 0;
	// expectations of the previous slot, checked while the next one decodes
	int last_wr = 0, last_r = 0, pend = 0;
	logic [7:0] hi[7] = '{8'h10, 8'hb5, 8'h0a, 8'h88, 8'h80, 8'h98, 8'hb0};
	logic [7:0] lo[7] = '{8'h01, 8'h00, 8'h01, 8'h07, 8'h07, 8'h07, 8'h00};
	always #4 clk = ~clk;
	byte_and_bit_execute_ops dut (.*);
	file_mem fm (.*);
	task automatic final_report;
		$display("checks %0d errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	task automatic chk(string n, logic [7:0] s, logic [7:0] e);
		num_checks++;
		if (s !== e) begin
			n_errors++;
			$display("[FAIL] %s exp %h seen %h", n, e, s);
		end
	endtask
	// one instruction slot, driven at the edge that opens decode; the previous
	// slot's results are settled by the following falling edge
	task automatic run(logic [15:0] w);
		int a, f, r, b, d, wr, un, sk;
		instr_word <= w;
		@(negedge clk);
		if (pend) begin
			chk("acc", working_accumulator, 8'(acc));
			chk("flags", {carry_flag, nibble_carry_flag, signed_overflow_flag, zero_flag}, 8'({c[0], dc[0], ov[0], z[0]}));
			chk("write", file_wr, 8'(last_wr));
			if (last_wr) chk("wdata", file_wdata, 8'(last_r));
		end
		pend = 1;
		a = acc;
		f = mm[w[7:0]];
		b = w[10:8];
		d = w[8];
		wr = 0;
		un = 0;
		r = 0;
		sk = skip;
		skip = 0;
		if (sk) ;
		else if (w[15:9] == 7'h08) begin
			r = a + f + c;
			dc = ((a & 15) + (f & 15) + c) >> 4;
			c = r >> 8;
			r = r & 255;
			ov = ((a ^ r) & (f ^ r) & 128) != 0;
			z = r == 0;
			wr = d;
			if (!d) acc = r;
		end else if (w[15:8] == 8'hb5) begin
			acc = a & w[7:0];
			z = acc == 0;
		end else if (w[15:9] == 7'h05) begin
			r = a & f;
			z = r == 0;
			wr = d;
			if (!d) acc = r;
		end else if (w[15:12] == 4'h8) begin
			r = w[11] ? f & ~(1 << b) : f | (1 << b);
			wr = 1;
		end else if (w[15:11] == 5'h13) skip = !f[b];
		else un = 1;
		if (wr) mm[w[7:0]] = r;
		last_wr = wr;
		last_r = r;
		repeat (2) @(posedge clk);
		@(negedge clk);
		chk("skip", skip_active, 8'(sk));
		chk("addr", file_addr, w[7:0]);
		if (!sk) chk("unknown", unknown_op, 8'(un));
		repeat (2) @(posedge clk);
	endtask
	// hang guard: 300 slots of 4 cycles fit well inside
	always @(posedge clk) begin
		cyc++;
		if (cyc == 3000) begin
			n_errors++;
			final_report;
		end
	end
	// random mix of all op kinds; first two use the address extremes
	initial begin
		int k;
		logic [7:0] a8;
		logic [31:0] rv;
		void'($urandom(32'h98cd_c93c));
		foreach (mm[i]) mm[i] = (i * 37 + 5) & 255;
		repeat (16) @(posedge clk);
		srst <= 1'b0;
		for (int i = 0; i < 300; i++) begin
			k = $urandom % 7;
			rv = $urandom;
			a8 = i < 2 ? 8'(255 * i) : rv[15:8];
			run({hi[k] | (rv[7:0] & lo[k]), a8});
		end
		// one idle slot so the last real slot's results get compared
		run(16'hb000);
		final_report;
	end
endmodule
